/* File: inc/tes_pkg.sv */
// Package for the transmit event status block: bit positions and resets
package tes_pkg;
    // Bit positions inside the transmit event status register
    localparam int TES_BIT_OSC = 7;
    localparam int TES_BIT_LOWBAT = 6;
    localparam int TES_BIT_NFULL = 5;
    localparam int TES_BIT_HALF = 4;
    localparam int TES_BIT_EMPTY = 3;
    localparam int TES_BIT_BERR = 2;
    localparam int TES_BIT_DONE = 1;
    localparam int TES_BIT_ERR = 0;
    // Register width and reset value of the sticky flags
    localparam int TES_REG_W = 8;
    localparam logic [7:0] TES_FLAGS_RST = 8'h00;
    // Fill thresholds of the transmit FIFO
    localparam logic [4:0] TES_NFULL_MAX = 5'h0f;
    localparam logic [4:0] TES_HALF_MAX = 5'h08;
    localparam logic [4:0] TES_FIFO_DEPTH = 5'h10;
endpackage : tes_pkg

/* File: logic/tes_status.sv */
// Transmit event status register with enable-gated interrupt output
`timescale 1ns/100ps
//
// How it works
// - Interrupt when any flag and its enable set
// - Flags may change on different cycles
// - Bit 7 sets when oscillator is stable
// - Bit 6 follows low battery detector
// - Low battery flag and interrupt off without power manager
// - Bit 5 set at fifteen or fewer bytes
// - Bit 4 set at eight or fewer bytes
// - Bit 3 set while FIFO is empty
// - Bit 2 set on underrun
// - Bit 2 set on write into full FIFO
// - Bit 2 cleared only by FIFO clear
// - Bit 1 set after checksum outside transactions
// - In transactions, bit 1 at transaction end
// - Reading register clears bit 1
// - Reading register clears bit 0
// - Done may stay clear on acknowledged failure
// - Acknowledge outcome may use receive flags
// - Bit 0 set on acknowledge timeout
// - Bit 0 only sets in transaction mode
// - Flags reflect events regardless of enables
module tes_status
    import tes_pkg::*;
#(
    parameter int FIFO_CNT_W = 5 // Width of the FIFO byte count
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [FIFO_CNT_W-1:0] tx_fifo_count,
    input wire logic tx_fifo_write,
    input wire logic tx_fifo_clear,
    input wire logic [7:0] bytes_left,
    input wire logic osc_stable,
    input wire logic low_voltage_detect,
    input wire logic power_manager,
    input wire logic transaction_mode,
    input wire logic crc_sent,
    input wire logic transaction_end,
    input wire logic ack_timeout,
    input wire logic [7:0] irq_enable,
    input wire logic reg_read,
    input wire logic reg_write,
    output logic [7:0] tx_event_flags,
    output logic irq_out
);

    // Count must reach the FIFO depth; a narrower count can never show full
    if (FIFO_CNT_W < 5) begin : g_cnt_w_check
        $error("FIFO_CNT_W too small for FIFO depth");
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for analog and oscillator levels from outside
    logic [1:0] osc_sync; // Bit 1 is the only one read by logic
    logic [1:0] lvd_sync;

    // Two flops each; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            osc_sync <= 2'h0;
            lvd_sync <= 2'h0;
        end else begin
            osc_sync <= {osc_sync[0], osc_stable};
            lvd_sync <= {lvd_sync[0], low_voltage_detect};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Level flags derived from the FIFO count
    logic [FIFO_CNT_W-1:0] nfull_max;
    logic [FIFO_CNT_W-1:0] half_max;
    logic [FIFO_CNT_W-1:0] depth;
    assign nfull_max = FIFO_CNT_W'(TES_NFULL_MAX);
    assign half_max = FIFO_CNT_W'(TES_HALF_MAX);
    assign depth = FIFO_CNT_W'(TES_FIFO_DEPTH);

    logic fifo_empty;
    logic fifo_full;
    assign fifo_empty = (tx_fifo_count == '0);
    assign fifo_full = (tx_fifo_count >= depth);

    // Fill test shared by the two threshold flags and their checks
    function automatic logic fill_at_most(
        input logic [FIFO_CNT_W-1:0] count,
        input logic [FIFO_CNT_W-1:0] limit
    );
        return (count <= limit);
    endfunction : fill_at_most

    // Flags are built unmasked; only irq_out sees enables
    logic [7:0] next_flags;
    logic berr_q; // Sticky buffer error
    logic done_q; // Sticky completion
    logic err_q; // Sticky transmit error

    // Next view of every flag; levels are live, events are sticky
    always_comb begin
        next_flags = TES_FLAGS_RST;
        next_flags[TES_BIT_OSC] = osc_sync[1];
        // Low battery reads zero while the power manager is off
        next_flags[TES_BIT_LOWBAT] = lvd_sync[1] & power_manager;
        next_flags[TES_BIT_NFULL] = fill_at_most(tx_fifo_count, nfull_max);
        next_flags[TES_BIT_HALF] = fill_at_most(tx_fifo_count, half_max);
        next_flags[TES_BIT_EMPTY] = fifo_empty;
        next_flags[TES_BIT_BERR] = berr_q;
        next_flags[TES_BIT_DONE] = done_q;
        next_flags[TES_BIT_ERR] = err_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Event detection
    logic underrun;
    logic overflow;
    logic done_evt;
    logic err_evt;
    assign underrun = fifo_empty && (bytes_left != 8'h00);
    assign overflow = tx_fifo_write && fifo_full;
    // Completion source depends on transaction mode
    // A failed acknowledged send may bring no end pulse: done stays clear
    // Acknowledge outcomes reported on receive flags never reach here
    assign done_evt = transaction_mode ? transaction_end : crc_sent;
    assign err_evt = transaction_mode && ack_timeout;

    // Buffer error: set beats the FIFO clear; reads do not touch it
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            berr_q <= 1'b0;
        end else if (underrun || overflow) begin
            berr_q <= 1'b1;
        end else if (tx_fifo_clear) begin
            berr_q <= 1'b0;
        end
    end

    // Completion and error cleared by read; a same-cycle event wins
    // Flags are separate flops so they may update apart
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            if (done_evt) begin
                done_q <= 1'b1;
            end else if (reg_read) begin
                done_q <= 1'b0;
            end
            if (err_evt) begin
                err_q <= 1'b1;
            end else if (reg_read) begin
                err_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs; reg_write has no path into any flag
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            tx_event_flags <= TES_FLAGS_RST;
            irq_out <= 1'b0;
        end else begin
            tx_event_flags <= next_flags;
            irq_out <= |(next_flags & irq_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Interrupt output against the flags it is built from
    a_irq_gating: assert property (
        @(posedge core_clk) disable iff (!nrst)
        irq_out == |(tx_event_flags & irq_enable) || $changed(irq_enable))
        else $error("irq out disagrees with flags and enables");

    // Transmit error only in transaction mode
    a_err_mode_only: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (!transaction_mode && !err_q) |=> !err_q)
        else $error("tx error set outside transaction mode");

    a_err_timeout: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (transaction_mode && ack_timeout) |=> err_q)
        else $error("ack timeout did not raise tx error");

    // Buffer error set, hold and clear
    a_berr_sticky: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (berr_q && !tx_fifo_clear) |=> berr_q)
        else $error("buffer error dropped without fifo clear");

    a_berr_clear: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (tx_fifo_clear && !underrun && !overflow) |=> !berr_q)
        else $error("fifo clear did not drop buffer error");

    a_berr_overflow: assert property (
        @(posedge core_clk) disable iff (!nrst)
        overflow |=> ##1 tx_event_flags[TES_BIT_BERR])
        else $error("overflow did not raise buffer error");

    a_underrun_set: assert property (
        @(posedge core_clk) disable iff (!nrst)
        underrun |=> berr_q)
        else $error("underrun did not raise buffer error");

    // Read side effects on completion and error
    a_done_read: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (reg_read && !done_evt) |=> !done_q)
        else $error("read did not clear completion");

    a_err_read: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (reg_read && !err_evt) |=> !err_q)
        else $error("read did not clear tx error");

    // FIFO level flags
    a_empty_level: assert property (
        @(posedge core_clk) disable iff (!nrst)
        fifo_empty |=> tx_event_flags[TES_BIT_EMPTY]
            && tx_event_flags[TES_BIT_HALF])
        else $error("empty fifo not shown");

    a_not_empty: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !fifo_empty |=> !tx_event_flags[TES_BIT_EMPTY])
        else $error("empty shown with bytes in fifo");

    a_nfull_set: assert property (
        @(posedge core_clk) disable iff (!nrst)
        fill_at_most(tx_fifo_count, nfull_max)
            |=> tx_event_flags[TES_BIT_NFULL])
        else $error("not full flag missing");

    a_nfull_clear: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !fill_at_most(tx_fifo_count, nfull_max)
            |=> !tx_event_flags[TES_BIT_NFULL])
        else $error("not full flag set on full fifo");

    a_half_set: assert property (
        @(posedge core_clk) disable iff (!nrst)
        fill_at_most(tx_fifo_count, half_max)
            |=> tx_event_flags[TES_BIT_HALF])
        else $error("half empty flag missing");

    a_half_clear: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !fill_at_most(tx_fifo_count, half_max)
            |=> !tx_event_flags[TES_BIT_HALF])
        else $error("half empty flag set above threshold");

    // Supply and oscillator levels
    a_osc_follow: assert property (
        @(posedge core_clk) disable iff (!nrst)
        osc_sync[1] |=> tx_event_flags[TES_BIT_OSC])
        else $error("oscillator flag missing");

    a_osc_clear: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !osc_sync[1] |=> !tx_event_flags[TES_BIT_OSC])
        else $error("oscillator flag set before settling");

    a_lowbat_follow: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (lvd_sync[1] && power_manager) |=> tx_event_flags[TES_BIT_LOWBAT])
        else $error("low battery flag missing");

    a_lowbat_clear: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !lvd_sync[1] |=> !tx_event_flags[TES_BIT_LOWBAT])
        else $error("low battery flag set with supply good");

    a_lowbat_off: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !power_manager |=> !tx_event_flags[TES_BIT_LOWBAT])
        else $error("low battery set with power manager off");

    // Completion source per mode
    a_done_crc: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (!transaction_mode && crc_sent) |=> ##1 tx_event_flags[TES_BIT_DONE])
        else $error("completion missing after checksum");

    a_end_ignored: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (!transaction_mode && transaction_end && !crc_sent && !done_q)
            |=> !done_q)
        else $error("completion set by end outside transactions");

    a_done_txn: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (transaction_mode && transaction_end) |=> done_q)
        else $error("completion missing at transaction end");

    a_crc_ignored: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (transaction_mode && crc_sent && !transaction_end && !done_q)
            |=> !done_q)
        else $error("completion set by checksum inside transaction");

endmodule : tes_status

/* File: dv/tes_host_model.sv */
// Host model: issues status register reads, repeating one where needed
`timescale 1ns/100ps
module tes_host_model (
    input wire logic core_clk,
    input wire logic rd_req,
    input wire logic transaction_mode,
    input wire logic [7:0] tx_event_flags,
    output logic reg_read = 1'b0
);
    logic [2:0] wait_q = 3'h0; // Cycles left before a repeat read
    ////////////////////////////////////////////////////////////////////////
    // Done without error in a transaction may hide a late error bit,
    // so a second read follows; done with error is never read again
    always @(posedge core_clk) begin
        if (reg_read && transaction_mode && tx_event_flags[1]
                && !tx_event_flags[0]) begin
            wait_q <= 3'h4;
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end
        reg_read <= rd_req | (wait_q == 3'h1);
    end
endmodule : tes_host_model

/* File: dv/tes_status_tb.sv */
// Self-checking bench for the transmit event status block
`timescale 1ns/100ps
module tes_status_tb;
    import tes_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, rd_req, reg_read, irq_out;
    logic osc_stable = 1'b0, low_voltage_detect = 1'b0, power_manager;
    logic transaction_mode = 1'b0;
    logic [4:0] tx_fifo_count = 5'h10; // Full FIFO gives all-zero levels
    logic [7:0] bytes_left = 8'h00, irq_enable = 8'hff, tx_event_flags;
    logic [6:0] pv = 7'h00; // Pulses: wr clr crc end ack rd regwr
    int err_total = 0, total_checks = 0, seed = 44430;
    assign rd_req = pv[1];
    always #4 core_clk = ~core_clk;
    tes_status i_tes_status (.core_clk, .nrst, .tx_fifo_count,
        .tx_fifo_write(pv[6]), .tx_fifo_clear(pv[5]), .bytes_left,
        .osc_stable, .low_voltage_detect, .power_manager(power_manager),
        .transaction_mode, .crc_sent(pv[4]), .transaction_end(pv[3]),
        .ack_timeout(pv[2]), .irq_enable, .reg_read, .reg_write(pv[0]),
        .tx_event_flags, .irq_out);
    tes_host_model i_tes_host_model (.core_clk, .rd_req,
        .transaction_mode, .tx_event_flags, .reg_read);
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic pulse(input logic [6:0] m);
        @(posedge core_clk) pv <= m;
        @(posedge core_clk) pv <= 7'h00;
        tick(3);
    endtask : pulse
    task automatic cmp_flags(input logic [7:0] exp);
        total_checks++;
        if (tx_event_flags !== exp) begin
            err_total++;
            $display("ERROR %0t flags %h exp %h", $time, tx_event_flags, exp);
        end
    endtask : cmp_flags
    task automatic cmp_irq(input logic exp);
        total_checks++;
        if (irq_out !== exp) begin
            err_total++;
            $display("ERROR %0t irq %h exp %h", $time, irq_out, exp);
        end
    endtask : cmp_irq
    task automatic check(input logic [7:0] exp);
        cmp_flags(exp);
        cmp_irq(|(exp & irq_enable));
    endtask : check
    // Level part of the register for a given FIFO fill and supply state
    function automatic logic [7:0] lvl(input logic [4:0] c);
        return {osc_stable, low_voltage_detect & power_manager,
            c <= TES_NFULL_MAX, c <= TES_HALF_MAX, c == 5'h00, 3'h0};
    endfunction : lvl
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the tests need well under a thousand cycles
    initial begin
        #40000;
        err_total++;
        wrap_up();
    end
    initial begin
        power_manager = 1'b0;
        tick(2);
        check(TES_FLAGS_RST);
        tick(2);
        nrst <= 1'b1;
        // Every fill count first, then random counts; supplies and enables random throughout
        for (int i = 0; i < 48; i++) begin
            @(posedge core_clk);
            tx_fifo_count <= (i < 17) ? i[4:0] : 5'($unsigned($random(seed)) % 17);
            {osc_stable, low_voltage_detect, power_manager} <= 3'($random(seed));
            irq_enable <= 8'($random(seed));
            tick(5);
            check(lvl(tx_fifo_count));
        end
        $display("test levels done");
        @(posedge core_clk) {tx_fifo_count, osc_stable, low_voltage_detect} <= 7'h40;
        irq_enable <= 8'h04;
        pulse(7'h40);
        check(8'h04);
        pulse(7'h02);
        check(8'h04);
        pulse(7'h20);
        check(8'h00);
        @(posedge core_clk) {tx_fifo_count, bytes_left} <= 13'h0005;
        pulse(7'h20);
        check(8'h3c);
        @(posedge core_clk) bytes_left <= 8'h00;
        pulse(7'h20);
        check(8'h38);
        $display("test buffer error done");
        @(posedge core_clk) tx_fifo_count <= 5'h10;
        irq_enable <= 8'h03;
        pulse(7'h10);
        check(8'h02);
        pulse(7'h05);
        check(8'h02);
        pulse(7'h02);
        check(8'h00);
        @(posedge core_clk) transaction_mode <= 1'b1;
        pulse(7'h10);
        check(8'h00);
        pulse(7'h0c);
        check(8'h03);
        pulse(7'h02);
        check(8'h00);
        pulse(7'h08);
        check(8'h02);
        pulse(7'h02);
        tick(6);
        check(8'h00);
        $display("test completion done");
        wrap_up();
    end
endmodule : tes_status_tb
